//--- src/pcs_pkg.sv
// pcs_pkg: constants and types for the pc card socket signal layer
`default_nettype none
package pcs_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W       = 26;
  localparam int DATA_W       = 16;
  localparam int ATA_ADDR_W   = 3;
  // ------------------------------------------------------------
  // remapped address bit positions in disk attachment mode
  // ------------------------------------------------------------
  localparam int BIT_CABLE_SELECT     = 25;
  localparam int BIT_MS       = 24;
  localparam int BIT_VU       = 23;
  localparam int BIT_CD       = 9;
  // ------------------------------------------------------------
  // timing counts (clock cycles at 20 MHz)
  // ------------------------------------------------------------
  localparam int CLK_NS       = 50;
  localparam int SETUP_NS     = 100;
  localparam int STROBE_NS    = 250;
  localparam int HOLD_NS      = 50;
  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_KIND_NONE,
    PCS_KIND_MEM,
    PCS_KIND_IO,
    PCS_KIND_DISK
  } pcs_kind_t;
  typedef enum logic [1:0] {
    PCS_SIZE_EVEN,
    PCS_SIZE_ODD,
    PCS_SIZE_WORD
  } pcs_size_t;
endpackage
`default_nettype wire

//--- src/pcs_socket.sv
// pcs_socket: host side signal layer of a 16-bit pc card socket
// ------------------------------------------------------------
// Summary of operation
// - pin directions are taken from the host side; card driven pins are inputs.
// - sensed card kind reconfigures the affected connector lines.
// - sixteen data lines are shared: host drives writes, card drives reads.
// - two low byte enables, even and odd; both for word transfers.
// - memory access presents 26 address bits, reaching 64 megabytes.
// - io access uses the address lines to select the card port.
// - disk mode keeps A2..A0; bits 25,24,23,9 take alternate roles.
// - disk mode floats all other address lines.
// - unremapped signals keep their role or stay unused in disk mode.
// - output strobe goes low to read card memory.
// - register select low for attribute, high common; dma ack in disk.
// - card wait line stretches the cycle until released.
// - write strobe goes low to write card memory.
// ------------------------------------------------------------
`default_nettype none
module pcs_socket
  import pcs_pkg::*;
(
  // clock, reset, enable
  input  wire logic                          i_mclk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_ce,
  // user request side
  input  wire logic                          i_req,
  input  wire logic                          i_write,
  input  wire logic                          i_attr,
  input  wire logic                          i_dma_ack,
  input  wire pcs_pkg::pcs_size_t            i_size,
  input  wire logic [pcs_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [pcs_pkg::DATA_W-1:0]    i_wdata,
  input  wire pcs_pkg::pcs_kind_t            i_kind,
  input  wire logic                          i_cable_select,
  input  wire logic                          i_master_slave,
  input  wire logic                          i_vendor_unique,
  output logic                               o_busy,
  output logic                               o_done,
  output logic [pcs_pkg::DATA_W-1:0]         o_rdata,
  output logic                               o_card_ready,
  output pcs_pkg::pcs_kind_t                 o_mode,
  // card pins: strobes
  output logic                               o_even_byte_enable_n,
  output logic                               o_odd_byte_enable_n,
  output logic                               o_read_strobe_n,
  output logic                               o_write_strobe_n,
  output logic                               o_io_read_n,
  output logic                               o_io_write_n,
  output logic                               o_reg_select_n,
  // card pins: address, three signals per line
  input  wire logic [pcs_pkg::ADDR_W-1:0]    i_addr_pin,
  output logic [pcs_pkg::ADDR_W-1:0]         o_addr_pin,
  output logic [pcs_pkg::ADDR_W-1:0]         o_addr_oe,
  // card pins: data
  input  wire logic [pcs_pkg::DATA_W-1:0]    i_data_pin,
  output logic [pcs_pkg::DATA_W-1:0]         o_data_pin,
  output logic [pcs_pkg::DATA_W-1:0]         o_data_oe,
  // card pins: status inputs
  input  wire logic                          i_wait_n,
  input  wire logic                          i_card_ready_busy
);
  // ------------------------------------------------------------
  // types and state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_IDLE, PCS_SETUP, PCS_STROBE, PCS_HOLD
  } pcs_state_t;

  pcs_state_t              st_q, st_d;
  logic [3:0]              cnt_q, cnt_d;
  logic                    wr_q, wr_d;
  logic                    io_q, io_d;
  logic                    done_q, done_d;
  logic                    busy_q, busy_d;
  pcs_kind_t               mode_q, mode_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [ADDR_W-1:0]       aoe_q, aoe_d;
  logic [DATA_W-1:0]       wd_q, wd_d;
  logic [DATA_W-1:0]       doe_q, doe_d;
  logic [DATA_W-1:0]       rd_q, rd_d;
  logic                    ce1_q, ce1_d, ce2_q, ce2_d;
  logic                    oe_q, oe_d, we_q, we_d;
  logic                    ior_q, ior_d, iow_q, iow_d;
  logic                    reg_q, reg_d;
  logic                    wait_s, rdy_s, cd_s;
  logic [DATA_W-1:0]       din_s;

  // ------------------------------------------------------------
  // pin synchronisers for card driven inputs
  // ------------------------------------------------------------
  pcs_sync #(.W(DATA_W + 3)) u_sync (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_pin     ({i_data_pin, i_wait_n, i_card_ready_busy,
                 i_addr_pin[BIT_CD]}),
    .i_rst_val ('0),
    .o_val     ({din_s, wait_s, rdy_s, cd_s})
  );

  // even enable for even or word, odd enable for odd or word
  function automatic logic [1:0] lane_n(input pcs_size_t s);
    lane_n = {~(s != PCS_SIZE_EVEN), ~(s != PCS_SIZE_ODD)};
  endfunction

  // address pin drive mask for the current mode
  function automatic logic [ADDR_W-1:0] addr_mask(input pcs_kind_t k);
    logic [ADDR_W-1:0] m;
    m = '0;
    if (k == PCS_KIND_DISK) begin
      m[ATA_ADDR_W-1:0] = '1;
      m[BIT_CABLE_SELECT]       = 1'b1;
      m[BIT_MS]         = 1'b1;
      m[BIT_VU]         = 1'b1;
    end else if (k != PCS_KIND_NONE) begin
      m = '1;
    end
    addr_mask = m;                             // others floated
  endfunction

  // ------------------------------------------------------------
  // cycle sequencer: next state
  // ------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    io_d   = io_q;
    done_d = 1'b0;
    mode_d = mode_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    doe_d  = doe_q;
    rd_d   = rd_q;
    ce1_d  = ce1_q;
    ce2_d  = ce2_q;
    oe_d   = oe_q;
    we_d   = we_q;
    ior_d  = ior_q;
    iow_d  = iow_q;
    reg_d  = reg_q;
    case (st_q)
      PCS_IDLE: begin
        mode_d = i_kind;
        aoe_d  = addr_mask(i_kind);
        if (i_req && i_kind != PCS_KIND_NONE) begin
          st_d  = PCS_SETUP;
          cnt_d = SETUP_CYC;
          wr_d  = i_write;
          io_d  = (i_kind == PCS_KIND_IO);
          wd_d  = i_wdata;
          addr_d = i_addr;
          if (i_kind == PCS_KIND_DISK) begin
            addr_d = '0;
            addr_d[ATA_ADDR_W-1:0] = i_addr[ATA_ADDR_W-1:0];
            addr_d[BIT_CABLE_SELECT] = i_cable_select;
            addr_d[BIT_MS]   = i_master_slave;
            addr_d[BIT_VU]   = i_vendor_unique;
            reg_d = ~i_dma_ack;
          end else begin
            reg_d = ~i_attr;
          end
          {ce2_d, ce1_d} = lane_n(i_size);
          doe_d = i_write ? '1 : '0;
        end
      end
      PCS_SETUP: begin
        aoe_d = aoe_q;
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          st_d  = PCS_STROBE;
          cnt_d = STROBE_CYC;
          oe_d  = ~(!wr_q && !io_q);
          we_d  = ~(wr_q && !io_q);
          ior_d = ~(!wr_q && io_q);
          iow_d = ~(wr_q && io_q);
        end
      end
      PCS_STROBE: begin
        aoe_d = aoe_q;
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else if (wait_s) begin             // stretched by card
          st_d  = PCS_HOLD;
          cnt_d = HOLD_CYC;
          rd_d  = din_s;
          oe_d  = 1'b1;
          we_d  = 1'b1;
          ior_d = 1'b1;
          iow_d = 1'b1;
        end
      end
      PCS_HOLD: begin
        aoe_d = aoe_q;
        if (cnt_q > 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          st_d   = PCS_IDLE;
          done_d = 1'b1;
          ce1_d  = 1'b1;
          ce2_d  = 1'b1;
          reg_d  = 1'b1;
          doe_d  = '0;                         // release data
        end
      end
      default: begin
        aoe_d = '0;
        st_d  = PCS_IDLE;
      end
    endcase
    busy_d = (st_d != PCS_IDLE);               // registered busy flag
  end

  // ------------------------------------------------------------
  // cycle sequencer: registers
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q   <= PCS_IDLE;
      cnt_q  <= 4'h0;
      wr_q   <= 1'b0;
      io_q   <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      mode_q <= PCS_KIND_NONE;
      addr_q <= ADDR_RST;
      aoe_q  <= '0;
      wd_q   <= DATA_RST;
      doe_q  <= '0;
      rd_q   <= DATA_RST;
      ce1_q  <= 1'b1;
      ce2_q  <= 1'b1;
      oe_q   <= 1'b1;
      we_q   <= 1'b1;
      ior_q  <= 1'b1;
      iow_q  <= 1'b1;
      reg_q  <= 1'b1;
    end else if (i_ce) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      io_q   <= io_d;
      done_q <= done_d;
      busy_q <= busy_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      aoe_q  <= aoe_d;
      wd_q   <= wd_d;
      doe_q  <= doe_d;
      rd_q   <= rd_d;
      ce1_q  <= ce1_d;
      ce2_q  <= ce2_d;
      oe_q   <= oe_d;
      we_q   <= we_d;
      ior_q  <= ior_d;
      iow_q  <= iow_d;
      reg_q  <= reg_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------
  assign o_busy               = busy_q;
  assign o_done               = done_q;
  assign o_rdata              = rd_q;
  assign o_card_ready         = rdy_s;  // same role in every mode
  assign o_mode               = mode_q;
  assign o_even_byte_enable_n = ce1_q;
  assign o_odd_byte_enable_n  = ce2_q;
  assign o_read_strobe_n      = oe_q;
  assign o_write_strobe_n     = we_q;
  assign o_io_read_n          = ior_q;
  assign o_io_write_n         = iow_q;
  assign o_reg_select_n       = reg_q;
  assign o_addr_pin           = addr_q;
  assign o_addr_oe            = aoe_q;
  assign o_data_pin           = wd_q;
  assign o_data_oe            = doe_q;
endmodule
`default_nettype wire

//--- src/pcs_sync.sv
// pcs_sync: three-stage pin synchroniser with agreement filter
`default_nettype none
module pcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  // pin side
  input  wire logic [W-1:0] i_pin,
  input  wire logic [W-1:0] i_rst_val,
  // synchronised side
  output logic      [W-1:0] o_val
);
  logic [W-1:0] s1_q, s2_q, s3_q, val_q;
  logic [W-1:0] val_d;

  // accept a change once second and third stages agree
  always_comb begin
    val_d = val_q;
    for (int k = 0; k < W; k++) begin
      if (s2_q[k] == s3_q[k]) begin
        val_d[k] = s2_q[k];
      end
    end
  end

  // register stages; reset constants only
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      val_q <= '0;
    end else if (i_ce) begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      val_q <= val_d;
    end
  end

  assign o_val = val_q;
endmodule
`default_nettype wire

//--- test/pcs_card_model.sv
// pcs_card_model: behavioural 16-bit card with eight word locations
`default_nettype none
module pcs_card_model (
  // clock and test control
  input  wire logic        i_mclk,
  input  wire logic        i_slow,
  // host strobes and address
  input  wire logic        i_even_n,
  input  wire logic        i_odd_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_data,
  // card outputs
  output logic      [15:0] o_data,
  output logic             o_wait_n,
  output logic             o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [8];
  logic [15:0] last;
  logic        drive;
  int          cnt;
  initial begin
    foreach (mem[k]) mem[k] = 16'h0000;
    last = 16'h0000;
    cnt = 0;
  end
  // drive only while selected and read strobed, else a moving value
  assign drive = !i_rd_n && !(i_even_n && i_odd_n);
  assign o_data = drive ? mem[i_addr] : ~last;
  // busy while servicing a strobe
  assign o_ready = i_rd_n && i_wr_n;
  // slow card holds wait low for the first six strobe cycles
  assign o_wait_n = !(i_slow && !o_ready && cnt < 6);
  // store enabled lanes, count strobe cycles
  always @(posedge i_mclk) begin
    last <= o_data;
    cnt <= o_ready ? 0 : cnt + 1;
    if (!i_wr_n && !i_even_n) mem[i_addr][7:0] <= i_data[7:0];
    if (!i_wr_n && !i_odd_n) mem[i_addr][15:8] <= i_data[15:8];
  end
endmodule
`default_nettype wire

//--- test/pcs_socket_properties.sv
// pcs_socket_properties: pin level assertions for the socket layer
`default_nettype none
module pcs_socket_properties
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic                  i_mclk,
  input wire logic                  i_resetn,
  input wire logic                  i_ce,
  // request side
  input wire logic                  i_req,
  input wire pcs_pkg::pcs_kind_t    i_kind,
  input wire logic                  o_busy,
  input wire logic                  o_done,
  input wire pcs_pkg::pcs_kind_t    o_mode,
  // card pins
  input wire logic                  o_even_byte_enable_n,
  input wire logic                  o_odd_byte_enable_n,
  input wire logic                  o_read_strobe_n,
  input wire logic                  o_write_strobe_n,
  input wire logic                  o_io_read_n,
  input wire logic [ADDR_W-1:0]     o_addr_oe,
  input wire logic [DATA_W-1:0]     o_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------
  // strobes and lanes
  // ----------------------------------------------------------
  strobe_exclusive_a: assert property (
    o_read_strobe_n || o_write_strobe_n)
    else $error("read and write strobes low together");
  lane_enable_a: assert property (
    (!o_read_strobe_n || !o_write_strobe_n)
    |-> !(o_even_byte_enable_n && o_odd_byte_enable_n))
    else $error("strobe without byte enable");
  data_release_a: assert property (
    |o_data_oe |-> o_busy && o_read_strobe_n && o_io_read_n)
    else $error("data driven outside a write");
  io_strobe_a: assert property (
    !o_io_read_n |-> o_mode == PCS_KIND_IO)
    else $error("port strobe outside io mode");
  // ----------------------------------------------------------
  // address lines by mode
  // ----------------------------------------------------------
  disk_float_a: assert property (
    (o_mode == PCS_KIND_DISK && o_busy)
    |-> (o_addr_oe & 26'h07FFFF8) == 26'h0000000)
    else $error("unused address line driven in disk mode");
  disk_keep_a: assert property (
    (o_mode == PCS_KIND_DISK && o_busy)
    |-> o_addr_oe[2:0] == 3'h7 && o_addr_oe[25:23] == 3'h7)
    else $error("kept address line not driven in disk mode");
  none_float_a: assert property (
    o_mode == PCS_KIND_NONE |-> o_addr_oe == 26'h0000000)
    else $error("address driven with no card");
  // ----------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------
  accept_busy_a: assert property (
    (i_ce && i_req && !o_busy && !o_done
    && i_kind != PCS_KIND_NONE) |=> o_busy)
    else $error("request not taken");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  cycle_bound_a: assert property ($rose(o_busy) |-> ##[7:60] o_done)
    else $error("cycle did not finish in time");
endmodule
bind pcs_socket pcs_socket_properties u_props (.*);
`default_nettype wire

//--- test/test_pcs_socket.sv
// test_pcs_socket: self-checking bench for the socket signal layer
`default_nettype none
module test_pcs_socket;
  import pcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_resetn, i_ce, i_req, i_write, i_attr, i_dma_ack;
  logic i_cable_select, i_master_slave, i_vendor_unique;
  logic i_wait_n, i_card_ready_busy, slow, mem_s, io_s, reg_s;
  logic o_busy, o_done, o_card_ready, o_reg_select_n;
  logic o_even_byte_enable_n, o_odd_byte_enable_n;
  logic o_read_strobe_n, o_write_strobe_n, o_io_read_n, o_io_write_n;
  pcs_size_t         i_size;
  pcs_kind_t         i_kind, o_mode;
  logic [ADDR_W-1:0] i_addr, i_addr_pin, o_addr_pin, o_addr_oe, a_s, oe_s;
  logic [DATA_W-1:0] i_wdata, o_rdata, i_data_pin, o_data_pin, o_data_oe;
  logic [DATA_W-1:0] c_data, d;
  logic [15:0]       ref_mem [8];
  int                n_mismatch, checked, lat, fast;
  pcs_socket dut (.*);
  pcs_card_model card (.i_mclk(i_mclk), .i_slow(slow),
    .i_even_n(o_even_byte_enable_n), .i_odd_n(o_odd_byte_enable_n),
    .i_rd_n(o_read_strobe_n & o_io_read_n),
    .i_wr_n(o_write_strobe_n & o_io_write_n), .i_addr(i_addr_pin[2:0]),
    .i_data(i_data_pin), .o_data(c_data), .o_wait_n(i_wait_n),
    .o_ready(i_card_ready_busy));
  // wire levels; card detect pulled low when the host floats it
  assign i_data_pin = (o_data_pin & o_data_oe) | (c_data & ~o_data_oe);
  assign i_addr_pin = (o_addr_pin & o_addr_oe) |
    ({~o_addr_pin[25:10], 1'b0, ~o_addr_pin[8:0]} & ~o_addr_oe);
  initial begin
    i_mclk = 0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one socket cycle; records what the pins showed under the strobe
  task automatic run(input logic w, input pcs_size_t s,
                     input logic [25:0] a, input logic [15:0] v);
    int n;
    @(posedge i_mclk); #2;
    i_req = 1; i_write = w; i_size = s; i_addr = a; i_wdata = v;
    @(posedge i_mclk); #2;
    i_req = 0; n = 0; lat = 1; mem_s = 0; io_s = 0;
    while (o_done !== 1'b1 && n < 200) begin
      if (!(o_read_strobe_n && o_write_strobe_n)) mem_s = 1;
      if (!(o_io_read_n && o_io_write_n)) io_s = 1;
      if (!(o_read_strobe_n && o_write_strobe_n &&
            o_io_read_n && o_io_write_n)) begin
        a_s = o_addr_pin; oe_s = o_addr_oe; reg_s = o_reg_select_n;
      end
      @(posedge i_mclk); #2;
      n++; lat++;
    end
    if (n == 200) n_mismatch++;
    if (w && s != PCS_SIZE_ODD) ref_mem[a[2:0]][7:0] = v[7:0];
    if (w && s != PCS_SIZE_EVEN) ref_mem[a[2:0]][15:8] = v[15:8];
  endtask
  task automatic set_kind(input pcs_kind_t k);
    i_kind = k;
    repeat (3) @(posedge i_mclk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    n_mismatch++;
    end_sim;
  end
  initial begin
    {i_resetn, i_ce, i_req, i_write, i_attr, i_dma_ack, slow} = 7'h20;
    {i_cable_select, i_master_slave, i_vendor_unique} = 3'h0;
    i_size = PCS_SIZE_WORD; i_kind = PCS_KIND_MEM;
    i_addr = 26'h0000000; i_wdata = 16'h0000;
    n_mismatch = 0; checked = 0;
    foreach (ref_mem[k]) ref_mem[k] = 16'h0000;
    repeat (6) @(posedge i_mclk);
    #2 i_resetn = 1;
    repeat (5) @(posedge i_mclk);
    void'($urandom(77));
    // random words into all eight card locations, read back with random high address bits
    for (int i = 0; i < 8; i++) run(1, PCS_SIZE_WORD, 26'(i), 16'($urandom));
    for (int i = 0; i < 8; i++) begin
      d = ref_mem[i];
      run(0, PCS_SIZE_WORD, {23'($urandom), 3'(i)}, 16'h0000);
      chk(o_rdata, d);
      chk(a_s, i_addr);
      chk({reg_s, mem_s, io_s}, 3'h6);
    end
    fast = lat;
    chk(lat >= 9, 1);
    $display("test memory words done");
    // single lanes into one word, then an attribute read
    run(1, PCS_SIZE_EVEN, 26'h0000001, 16'h33A5);
    run(1, PCS_SIZE_ODD, 26'h0000001, 16'h5A77);
    i_attr = 1;
    run(0, PCS_SIZE_WORD, 26'h0000001, 16'h0000);
    chk(o_rdata, ref_mem[1]);
    chk(reg_s, 0);
    i_attr = 0;
    $display("test byte lanes done");
    // port accesses use the port strobes only
    set_kind(PCS_KIND_IO);
    run(1, PCS_SIZE_WORD, 26'h0000002, 16'hC3D2);
    run(0, PCS_SIZE_WORD, 26'h0000002, 16'h0000);
    chk({io_s, mem_s}, 2'h2);
    chk(o_rdata, 16'hC3D2);
    $display("test io ports done");
    // disk mode remaps the high lines and floats the rest
    {i_cable_select, i_master_slave, i_vendor_unique, i_dma_ack} = 4'hB;
    set_kind(PCS_KIND_DISK);
    run(0, PCS_SIZE_WORD, 26'h3FFFFF5, 16'h0000);
    chk(oe_s, 26'h3800007);
    chk(o_mode, PCS_KIND_DISK);
    chk({a_s[25:23], a_s[2:0]}, 6'h2D);
    chk(reg_s, 0);
    chk(o_rdata, ref_mem[5]);
    i_dma_ack = 0;
    $display("test disk mode done");
    // slow card stretches the cycle
    set_kind(PCS_KIND_MEM);
    slow = 1;
    run(0, PCS_SIZE_WORD, 26'h0000006, 16'h0000);
    chk(lat > fast, 1);
    chk(o_rdata, ref_mem[6]);
    slow = 0;
    $display("test wait stretch done");
    // no card: request ignored and lines floated
    set_kind(PCS_KIND_NONE);
    @(posedge i_mclk); #2 i_req = 1;
    @(posedge i_mclk); #2 i_req = 0;
    repeat (2) @(posedge i_mclk);
    chk({o_busy, o_addr_oe}, 27'h0000000);
    chk(o_mode, PCS_KIND_NONE);
    chk(o_card_ready, 1);
    $display("test no card done");
    end_sim;
  end
endmodule
`default_nettype wire
